// >>> ssi_pkg.sv
package ssi_pkg;
	// register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CMD = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
	localparam logic [7:0] ADDR_CHAN_PAT = 8'h14;
	localparam logic [7:0] ADDR_CASC_TX = 8'h18;
	localparam logic [7:0] ADDR_CASC_RX = 8'h1C;
	// control fields
	localparam int CTRL_SRC_LSB = 0;
	localparam int CTRL_QUAL_LSB = 2;
	localparam int CTRL_MASTER_BIT = 4;
	// command bits
	localparam int CMD_SW_START = 0;
	localparam int CMD_CLR_ABORT = 1;
	localparam int CMD_CONNECT = 2;
	localparam int CMD_STOP = 3;
	// interrupt bits
	localparam int IRQ_STARTED = 0;
	localparam int IRQ_ABORTED = 1;
	localparam int IRQ_DONE = 2;
	localparam int IRQ_CASC_RX = 3;
	localparam int IRQ_BITS = 4;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// first abort phase length
	localparam int ABORT_FLASH_NS = 100000;
	localparam int CLK_PERIOD_NS = 8;
	localparam int ABORT_FLASH_CYCLES = ABORT_FLASH_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0]
	{
		SRC_OFF = 2'b00,
		SRC_HW = 2'b01,
		SRC_SW = 2'b10
	} ssi_src_type;

	typedef enum logic [1:0]
	{
		QUAL_UNUSED = 2'b00,
		QUAL_HIGH = 2'b01,
		QUAL_LOW = 2'b10
	} ssi_qual_type;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01,
		ST_ABORT_FLASH = 2'b10,
		ST_ABORT_HOLD = 2'b11
	} ssi_state_type;
endpackage

// >>> ssi_interlock.sv
// Behaviour
// - engaged emergency stop makes every start command ignored
// - emergency stop while running forces all channels inactive at once
// - aborted indicator set in same cycle channels forced inactive
// - first abort phase: power, sequence, frequency, zero fiber outputs on
// - after short delay only power and abort fiber outputs stay on
// - abort drops host session; reconnect only with stop released
// - high qualify mode: start allowed only while qualify input high
// - low qualify mode: start allowed only while qualify input low
// - unused qualify mode: qualify input ignored
// - with qualification enabled, no start until condition met
// - qualification is level sensitive, no edge needed
// - qualify term combines with other start conditions as extra gate
// - cascade master drives sync clock and zero, slave follows them
// - cascade commands travel on own inter-unit link, not host link
// - start source selection: off, hardware only, or software only
// - aborted indicator stays set until host clear command
`timescale 1ns/1ps
module ssi_interlock
	import ssi_pkg::*;
#(
	parameter int NUM_CHAN = 32,
	parameter int ABORT_FLASH_LEN = ABORT_FLASH_CYCLES
)
(
	input wire logic CLK_SYS_IN,
	input wire logic RST_N_IN,
	input wire logic [7:0] S_AXI_AWADDR_IN,
	input wire logic S_AXI_AWVALID_IN,
	output logic S_AXI_AWREADY_OUT,
	input wire logic [31:0] S_AXI_WDATA_IN,
	input wire logic [3:0] S_AXI_WSTRB_IN,
	input wire logic S_AXI_WVALID_IN,
	output logic S_AXI_WREADY_OUT,
	output logic [1:0] S_AXI_BRESP_OUT,
	output logic S_AXI_BVALID_OUT,
	input wire logic S_AXI_BREADY_IN,
	input wire logic [7:0] S_AXI_ARADDR_IN,
	input wire logic S_AXI_ARVALID_IN,
	output logic S_AXI_ARREADY_OUT,
	output logic [31:0] S_AXI_RDATA_OUT,
	output logic [1:0] S_AXI_RRESP_OUT,
	output logic S_AXI_RVALID_OUT,
	input wire logic S_AXI_RREADY_IN,
	input wire logic ESTOP_IN,
	input wire logic HW_START_IN,
	input wire logic QUALIFY_IN,
	input wire logic FREQ_LOCK_IN,
	input wire logic ZERO_PRESENT_IN,
	input wire logic LOCAL_SYNC_CLK_IN,
	input wire logic LOCAL_SYNC_ZERO_IN,
	input wire logic CASC_SYNC_CLK_IN,
	input wire logic CASC_SYNC_ZERO_IN,
	input wire logic [31:0] CASC_DATA_IN,
	input wire logic CASC_STB_IN,
	output logic [NUM_CHAN-1:0] CHAN_OUT,
	output logic FIB_POWER_OUT,
	output logic FIB_SEQUENCE_OUT,
	output logic FIB_FREQ_OUT,
	output logic FIB_ZERO_OUT,
	output logic FIB_ABORT_OUT,
	output logic SESSION_OUT,
	output logic CASC_SYNC_CLK_OUT,
	output logic CASC_SYNC_ZERO_OUT,
	output logic SYNC_CLK_OUT,
	output logic SYNC_ZERO_OUT,
	output logic [31:0] CASC_DATA_OUT,
	output logic CASC_STB_OUT,
	output logic IRQ_OUT
);
	localparam int CW = $clog2(ABORT_FLASH_LEN + 1);

	logic [31:0] ctrl;
	logic [NUM_CHAN-1:0] chan_pat;
	logic [IRQ_BITS-1:0] irq_stat;
	logic [IRQ_BITS-1:0] irq_mask;
	logic [31:0] casc_rx;
	ssi_state_type state;
	logic [CW-1:0] flash_cnt;
	logic aborted;
	logic hw_start_prev;
	logic wr_go;
	logic rd_go;
	logic cmd_wr;
	logic sw_start_cmd;
	logic clr_abort_cmd;
	logic connect_cmd;
	logic stop_cmd;
	logic qual_ok;
	logic src_ok;
	logic start_ok;
	logic abort_now;
	logic is_master;
	ssi_src_type src_sel;
	ssi_qual_type qual_sel;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;

	function automatic logic known_addr(input logic [7:0] a);
		known_addr = (a == ADDR_CTRL) || (a == ADDR_CMD) ||
			(a == ADDR_STATUS) || (a == ADDR_IRQ_STAT) ||
			(a == ADDR_IRQ_MASK) || (a == ADDR_CHAN_PAT) ||
			(a == ADDR_CASC_TX) || (a == ADDR_CASC_RX);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				r[i*8 +: 8] = data[i*8 +: 8];
		end
		merge = r;
	endfunction

	// write and read handshakes happen the cycle after ready rises
	assign wr_go = S_AXI_AWREADY_OUT && S_AXI_AWVALID_IN &&
		S_AXI_WVALID_IN;
	assign rd_go = S_AXI_ARREADY_OUT && S_AXI_ARVALID_IN;
	assign cmd_wr = wr_go && (S_AXI_AWADDR_IN == ADDR_CMD) &&
		S_AXI_WSTRB_IN[0];
	assign sw_start_cmd = cmd_wr && S_AXI_WDATA_IN[CMD_SW_START];
	assign clr_abort_cmd = cmd_wr && S_AXI_WDATA_IN[CMD_CLR_ABORT];
	assign connect_cmd = cmd_wr && S_AXI_WDATA_IN[CMD_CONNECT];
	assign stop_cmd = cmd_wr && S_AXI_WDATA_IN[CMD_STOP];

	assign src_sel = ssi_src_type'(ctrl[CTRL_SRC_LSB +: 2]);
	assign qual_sel = ssi_qual_type'(ctrl[CTRL_QUAL_LSB +: 2]);
	assign is_master = ctrl[CTRL_MASTER_BIT];

	// qualify is a level check; an unknown code blocks start
	always_comb
	begin
		case (qual_sel)
			QUAL_HIGH: qual_ok = QUALIFY_IN;
			QUAL_LOW: qual_ok = !QUALIFY_IN;
			QUAL_UNUSED: qual_ok = 1'b1;
			default: qual_ok = 1'b0;
		endcase
	end

	always_comb
	begin
		case (src_sel)
			SRC_HW: src_ok = HW_START_IN && !hw_start_prev;
			SRC_SW: src_ok = sw_start_cmd;
			default: src_ok = 1'b0;
		endcase
	end

	assign start_ok = src_ok && !ESTOP_IN && qual_ok;
	assign abort_now = (state == ST_RUN) && ESTOP_IN;

	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
			hw_start_prev <= 1'b0;
		else
			hw_start_prev <= HW_START_IN;
	end

	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			state <= ST_IDLE;
			flash_cnt <= '0;
		end
		else
		begin
			case (state)
				ST_IDLE:
				begin
					if (start_ok)
						state <= ST_RUN;
				end
				ST_RUN:
				begin
					if (ESTOP_IN)
					begin
						state <= ST_ABORT_FLASH;
						flash_cnt <= CW'(ABORT_FLASH_LEN - 1);
					end
					else if (stop_cmd)
						state <= ST_IDLE;
				end
				ST_ABORT_FLASH:
				begin
					if (flash_cnt == '0)
						state <= ST_ABORT_HOLD;
					else
						flash_cnt <= flash_cnt - 1'b1;
				end
				ST_ABORT_HOLD:
				begin
					if (clr_abort_cmd)
						state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// aborted set with the forcing edge
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
			aborted <= 1'b0;
		else if (abort_now)
			aborted <= 1'b1;
		else if (clr_abort_cmd && state == ST_ABORT_HOLD)
			aborted <= 1'b0;
	end

	// outputs driven only while running and stop released
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
			CHAN_OUT <= '0;
		else if (state == ST_RUN && !ESTOP_IN)
			CHAN_OUT <= chan_pat;
		else
			CHAN_OUT <= '0;
	end

	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			FIB_POWER_OUT <= 1'b0;
			FIB_SEQUENCE_OUT <= 1'b0;
			FIB_FREQ_OUT <= 1'b0;
			FIB_ZERO_OUT <= 1'b0;
			FIB_ABORT_OUT <= 1'b0;
		end
		else
		begin
			FIB_POWER_OUT <= 1'b1;
			// first phase all on except abort
			// phase two shows on the edge the counter expires, not one later
			if (abort_now || (state == ST_ABORT_FLASH && flash_cnt != '0))
			begin
				FIB_SEQUENCE_OUT <= 1'b1;
				FIB_FREQ_OUT <= 1'b1;
				FIB_ZERO_OUT <= 1'b1;
				FIB_ABORT_OUT <= 1'b0;
			end
			else if (state == ST_ABORT_FLASH || state == ST_ABORT_HOLD)
			begin
				FIB_SEQUENCE_OUT <= 1'b0;
				FIB_FREQ_OUT <= 1'b0;
				FIB_ZERO_OUT <= 1'b0;
				FIB_ABORT_OUT <= 1'b1;
			end
			else
			begin
				FIB_SEQUENCE_OUT <= (state == ST_RUN) ||
					(state == ST_IDLE && start_ok);
				FIB_FREQ_OUT <= FREQ_LOCK_IN;
				FIB_ZERO_OUT <= ZERO_PRESENT_IN;
				FIB_ABORT_OUT <= 1'b0;
			end
		end
	end

	// abort drops session; connect needs stop released
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
			SESSION_OUT <= 1'b0;
		else if (abort_now)
			SESSION_OUT <= 1'b0;
		else if (connect_cmd && !ESTOP_IN)
			SESSION_OUT <= 1'b1;
	end

	// master drives cascade sync, slave uses incoming lines
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			CASC_SYNC_CLK_OUT <= 1'b0;
			CASC_SYNC_ZERO_OUT <= 1'b0;
			SYNC_CLK_OUT <= 1'b0;
			SYNC_ZERO_OUT <= 1'b0;
		end
		else
		begin
			CASC_SYNC_CLK_OUT <= is_master && LOCAL_SYNC_CLK_IN;
			CASC_SYNC_ZERO_OUT <= is_master && LOCAL_SYNC_ZERO_IN;
			SYNC_CLK_OUT <= is_master ? LOCAL_SYNC_CLK_IN :
				CASC_SYNC_CLK_IN;
			SYNC_ZERO_OUT <= is_master ? LOCAL_SYNC_ZERO_IN :
				CASC_SYNC_ZERO_IN;
		end
	end

	// inter-unit command link separate from host bus
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			CASC_DATA_OUT <= '0;
			CASC_STB_OUT <= 1'b0;
			casc_rx <= '0;
		end
		else
		begin
			CASC_STB_OUT <= wr_go && (S_AXI_AWADDR_IN == ADDR_CASC_TX);
			if (wr_go && S_AXI_AWADDR_IN == ADDR_CASC_TX)
				CASC_DATA_OUT <= S_AXI_WDATA_IN;
			if (CASC_STB_IN)
				casc_rx <= CASC_DATA_IN;
		end
	end

	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			ctrl <= CTRL_RESET;
			chan_pat <= '0;
			irq_mask <= '0;
		end
		else if (wr_go)
		begin
			if (S_AXI_AWADDR_IN == ADDR_CTRL)
				ctrl <= merge(ctrl, S_AXI_WDATA_IN, S_AXI_WSTRB_IN);
			else if (S_AXI_AWADDR_IN == ADDR_IRQ_MASK)
				irq_mask <= S_AXI_WDATA_IN[IRQ_BITS-1:0];
			else if (S_AXI_AWADDR_IN == ADDR_CHAN_PAT)
				chan_pat <= S_AXI_WDATA_IN[NUM_CHAN-1:0];
		end
	end

	// events win over a simultaneous write-one clear
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
			irq_stat <= '0;
		else
		begin
			for (int i = 0; i < IRQ_BITS; i++)
			begin
				if (wr_go && S_AXI_AWADDR_IN == ADDR_IRQ_STAT &&
					S_AXI_WDATA_IN[i])
					irq_stat[i] <= 1'b0;
			end
			if (state == ST_IDLE && start_ok)
				irq_stat[IRQ_STARTED] <= 1'b1;
			if (abort_now)
				irq_stat[IRQ_ABORTED] <= 1'b1;
			if (state == ST_RUN && !ESTOP_IN && stop_cmd)
				irq_stat[IRQ_DONE] <= 1'b1;
			if (CASC_STB_IN)
				irq_stat[IRQ_CASC_RX] <= 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
			IRQ_OUT <= 1'b0;
		else
			IRQ_OUT <= |(irq_stat & irq_mask);
	end

	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			S_AXI_AWREADY_OUT <= 1'b0;
			S_AXI_WREADY_OUT <= 1'b0;
			S_AXI_BVALID_OUT <= 1'b0;
			S_AXI_BRESP_OUT <= RESP_OKAY;
		end
		else
		begin
			S_AXI_AWREADY_OUT <= S_AXI_AWVALID_IN && S_AXI_WVALID_IN &&
				!S_AXI_AWREADY_OUT && !S_AXI_BVALID_OUT;
			S_AXI_WREADY_OUT <= S_AXI_AWVALID_IN && S_AXI_WVALID_IN &&
				!S_AXI_AWREADY_OUT && !S_AXI_BVALID_OUT;
			if (wr_go)
			begin
				S_AXI_BVALID_OUT <= 1'b1;
				S_AXI_BRESP_OUT <= known_addr(S_AXI_AWADDR_IN) ?
					RESP_OKAY : RESP_SLVERR;
			end
			else if (S_AXI_BREADY_IN)
				S_AXI_BVALID_OUT <= 1'b0;
		end
	end

	always_comb
	begin
		next_rdata = '0;
		next_rresp = RESP_OKAY;
		if (S_AXI_ARADDR_IN == ADDR_CTRL)
			next_rdata = ctrl;
		else if (S_AXI_ARADDR_IN == ADDR_STATUS)
			next_rdata = {23'h00_0000, SESSION_OUT, qual_ok, ESTOP_IN,
				aborted, state, src_sel, 1'b0};
		else if (S_AXI_ARADDR_IN == ADDR_IRQ_STAT)
			next_rdata[IRQ_BITS-1:0] = irq_stat;
		else if (S_AXI_ARADDR_IN == ADDR_IRQ_MASK)
			next_rdata[IRQ_BITS-1:0] = irq_mask;
		else if (S_AXI_ARADDR_IN == ADDR_CHAN_PAT)
			next_rdata[NUM_CHAN-1:0] = chan_pat;
		else if (S_AXI_ARADDR_IN == ADDR_CASC_TX)
			next_rdata = CASC_DATA_OUT;
		else if (S_AXI_ARADDR_IN == ADDR_CASC_RX)
			next_rdata = casc_rx;
		else if (S_AXI_ARADDR_IN != ADDR_CMD)
			next_rresp = RESP_SLVERR;
	end

	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			S_AXI_ARREADY_OUT <= 1'b0;
			S_AXI_RVALID_OUT <= 1'b0;
			S_AXI_RDATA_OUT <= '0;
			S_AXI_RRESP_OUT <= RESP_OKAY;
		end
		else
		begin
			S_AXI_ARREADY_OUT <= S_AXI_ARVALID_IN && !S_AXI_ARREADY_OUT &&
				!S_AXI_RVALID_OUT;
			if (rd_go)
			begin
				S_AXI_RVALID_OUT <= 1'b1;
				S_AXI_RDATA_OUT <= next_rdata;
				S_AXI_RRESP_OUT <= next_rresp;
			end
			else if (S_AXI_RREADY_IN)
				S_AXI_RVALID_OUT <= 1'b0;
		end
	end
endmodule

// >>> ssi_interlock_assertions.sv
`timescale 1ns/1ps
module ssi_interlock_assertions
#(
	parameter int NUM_CHAN = 32,
	parameter int ABORT_FLASH_LEN = 4
)
(
	input wire logic CLK_SYS_IN,
	input wire logic RST_N_IN,
	input wire logic ESTOP_IN,
	input wire logic LOCAL_SYNC_CLK_IN,
	input wire logic [NUM_CHAN-1:0] CHAN_OUT,
	input wire logic FIB_POWER_OUT,
	input wire logic FIB_SEQUENCE_OUT,
	input wire logic FIB_FREQ_OUT,
	input wire logic FIB_ZERO_OUT,
	input wire logic FIB_ABORT_OUT,
	input wire logic SESSION_OUT,
	input wire logic CASC_SYNC_CLK_OUT,
	input wire logic SYNC_CLK_OUT,
	input wire logic CASC_STB_OUT
);
	default clocking dc @(posedge CLK_SYS_IN);
	endclocking
	default disable iff (!RST_N_IN);
	// stop arriving while a running sequence drives a nonzero channel pattern
	sequence s_hit;
		ESTOP_IN && FIB_SEQUENCE_OUT && CHAN_OUT != '0;
	endsequence
	sequence s_flash;
		FIB_POWER_OUT && FIB_SEQUENCE_OUT && FIB_FREQ_OUT && FIB_ZERO_OUT
			&& !FIB_ABORT_OUT;
	endsequence
	sequence s_hold;
		FIB_POWER_OUT && FIB_ABORT_OUT && !FIB_SEQUENCE_OUT && !FIB_FREQ_OUT
			&& !FIB_ZERO_OUT;
	endsequence
	property p_chan_off;
		ESTOP_IN |=> CHAN_OUT == '0;
	endproperty
	a_chan_off: assert property (p_chan_off)
		else $error("channels active after stop");
	property p_flash;
		s_hit |=> s_flash;
	endproperty
	a_flash: assert property (p_flash)
		else $error("first abort phase wrong");
	property p_hold;
		s_hit |=> s_flash ##ABORT_FLASH_LEN s_hold;
	endproperty
	a_hold: assert property (p_hold)
		else $error("second abort phase wrong");
	property p_drop;
		s_hit |=> !SESSION_OUT;
	endproperty
	a_drop: assert property (p_drop)
		else $error("session kept after abort");
	property p_reconn;
		ESTOP_IN |=> !$rose(SESSION_OUT);
	endproperty
	a_reconn: assert property (p_reconn)
		else $error("session opened during stop");
	property p_no_start;
		ESTOP_IN [*3] |-> !$rose(FIB_SEQUENCE_OUT);
	endproperty
	a_no_start: assert property (p_no_start)
		else $error("start during stop");
	property p_casc_clk;
		CASC_SYNC_CLK_OUT |-> $past(LOCAL_SYNC_CLK_IN);
	endproperty
	a_casc_clk: assert property (p_casc_clk)
		else $error("cascade clock not local");
	property p_sync_sel;
		CASC_SYNC_CLK_OUT |-> SYNC_CLK_OUT;
	endproperty
	a_sync_sel: assert property (p_sync_sel)
		else $error("master sync mismatch");
	property p_stb;
		CASC_STB_OUT |=> !CASC_STB_OUT;
	endproperty
	a_stb: assert property (p_stb)
		else $error("cascade strobe too long");
endmodule
bind ssi_interlock ssi_interlock_assertions
#(.NUM_CHAN(NUM_CHAN), .ABORT_FLASH_LEN(ABORT_FLASH_LEN)) u_chk
(
	.CLK_SYS_IN(CLK_SYS_IN), .RST_N_IN(RST_N_IN), .ESTOP_IN(ESTOP_IN),
	.LOCAL_SYNC_CLK_IN(LOCAL_SYNC_CLK_IN), .CHAN_OUT(CHAN_OUT),
	.FIB_POWER_OUT(FIB_POWER_OUT), .FIB_SEQUENCE_OUT(FIB_SEQUENCE_OUT),
	.FIB_FREQ_OUT(FIB_FREQ_OUT), .FIB_ZERO_OUT(FIB_ZERO_OUT),
	.FIB_ABORT_OUT(FIB_ABORT_OUT), .SESSION_OUT(SESSION_OUT),
	.CASC_SYNC_CLK_OUT(CASC_SYNC_CLK_OUT), .SYNC_CLK_OUT(SYNC_CLK_OUT),
	.CASC_STB_OUT(CASC_STB_OUT)
);

// >>> ssi_peer.sv
`timescale 1ns/1ps
module ssi_peer
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [3:0] delay_in,
	input wire logic [31:0] data_in,
	input wire logic stb_in,
	output logic [31:0] data_out,
	output logic stb_out,
	output logic sync_clk_out,
	output logic sync_zero_out
);
	logic [31:0] word;
	logic [3:0] wait_cnt;
	int div;
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			div <= 0;
		else
			div <= div + 1;
	end
	assign sync_clk_out = div[1];
	assign sync_zero_out = div[3] & div[2];
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			wait_cnt <= 4'h0;
			word <= '0;
			stb_out <= 1'b0;
		end
		else
		begin
			stb_out <= (wait_cnt == 4'h1);
			if (stb_in)
			begin
				word <= ~data_in;
				wait_cnt <= delay_in;
			end
			else if (wait_cnt != 4'h0)
				wait_cnt <= wait_cnt - 4'h1;
		end
	end
	// idle line keeps changing so a stale word is never read
	assign data_out = stb_out ? word : word ^ div;
endmodule

// >>> tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; \
$display("wrong value at %0t: got %h exp %h", $time, a, e); end end
module tb;
	import ssi_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, pat, w, e, chan, cdi, cdo;
	logic [1:0] bresp, rresp;
	logic awvalid, wvalid, bready, arvalid, rready, awready, wready;
	logic bvalid, arready, rvalid, estop, hw, qual, freq, zero, ok;
	logic lsc, lsz, csc, csz, cstb, cstbo, fp, fs, ff, fz, fa, sess, irq;
	logic [3:0] dly;
	logic sco, szo, csco, cszo;
	logic [1:0] v;
	logic [33:0] got, want;
	logic [33:0] exp_q[$];
	int num_errors = 0;
	int checked = 0;
	int cyc = 0;
	int seed = 7;
	ssi_interlock #(.ABORT_FLASH_LEN(4)) DUT
	(
		.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .S_AXI_AWADDR_IN(awaddr),
		.S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
		.S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hF),
		.S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready),
		.S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
		.S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr),
		.S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready),
		.S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
		.S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
		.ESTOP_IN(estop), .HW_START_IN(hw), .QUALIFY_IN(qual),
		.FREQ_LOCK_IN(freq), .ZERO_PRESENT_IN(zero),
		.LOCAL_SYNC_CLK_IN(lsc), .LOCAL_SYNC_ZERO_IN(lsz),
		.CASC_SYNC_CLK_IN(csc), .CASC_SYNC_ZERO_IN(csz),
		.CASC_DATA_IN(cdi), .CASC_STB_IN(cstb), .CHAN_OUT(chan),
		.FIB_POWER_OUT(fp), .FIB_SEQUENCE_OUT(fs), .FIB_FREQ_OUT(ff),
		.FIB_ZERO_OUT(fz), .FIB_ABORT_OUT(fa), .SESSION_OUT(sess),
		.CASC_SYNC_CLK_OUT(csco), .CASC_SYNC_ZERO_OUT(cszo),
		.SYNC_CLK_OUT(sco), .SYNC_ZERO_OUT(szo),
		.CASC_DATA_OUT(cdo), .CASC_STB_OUT(cstbo),
		.IRQ_OUT(irq)
	);
	ssi_peer u_peer
	(
		.clk_in(clk), .rst_n_in(rst_n), .delay_in(dly), .data_in(cdo),
		.stb_in(cstbo), .data_out(cdi), .stb_out(cstb),
		.sync_clk_out(csc), .sync_zero_out(csz)
	);
	function automatic logic [31:0] st(input logic [1:0] src, sta,
		input logic ab, es, qk, se);
		return {23'h00_0000, se, qk, es, ab, sta, src, 1'b0};
	endfunction
	// host traffic reaches this unit only over its register bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r = RESP_OKAY);
		@(posedge clk);
		exp_q.push_back({r, 32'h0000_0000});
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge clk); while (!awready);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge clk); while (!bvalid);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x,
		input logic [1:0] r = RESP_OKAY);
		@(posedge clk);
		exp_q.push_back({r, x});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		rready <= 1'b0;
	endtask
	task print_verdict;
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		forever #4 clk = ~clk;
	end
	always @(posedge clk)
		if (bvalid && bready || rvalid && rready)
		begin
			got = bvalid && bready ? {bresp, 32'h0000_0000} : {rresp, rdata};
			want = exp_q.pop_front();
			`CHK(got, want) // bus answer
		end
	always @(posedge clk)
	begin
		cyc++;
		lsc <= ~lsc;
		lsz <= (cyc % 8 == 0);
		if (cyc == 5000)
		begin
			num_errors++;
			print_verdict;
		end
	end
	initial
	begin
		{awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
		{arvalid, rready, estop, hw, qual, freq, zero, lsc, lsz} = '0;
		dly = 4'h1;
		pat = $random(seed) | 32'h0000_0001;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rd(ADDR_CTRL, CTRL_RESET); // starts disabled
		rd(ADDR_CMD, 32'h0000_0000);
		rd(8'h20, 32'h0000_0000, RESP_SLVERR);
		wr(8'h24, 32'hFFFF_FFFF, RESP_SLVERR);
		wr(ADDR_IRQ_MASK, 32'h0000_000F);
		rd(ADDR_IRQ_MASK, 32'h0000_000F);
		wr(ADDR_CHAN_PAT, pat);
		$display("test registers done");
		for (int s = 0; s < 3; s++)
			for (int m = 0; m < 3; m++)
				for (int l = 0; l < 2; l++)
				begin
					ok = m == 0 || m == 1 && l == 1 || m == 2 && l == 0;
					qual <= 1'(l);
					{freq, zero} <= 2'($random(seed));
					wr(ADDR_CTRL, 32'(s + 4 * m));
					hw <= 1'b1;
					wr(ADDR_CMD, 32'h0000_0001);
					e = st(2'(s), {1'b0, ok && s > 0}, 1'b0, 1'b0, ok, 1'b0);
					rd(ADDR_STATUS, e); // gate
					`CHK(chan, ok && s > 0 ? pat : '0) // run
					`CHK({ff, fz}, {freq, zero}) // normal fibers
					v = {csc, csz};
					@(posedge clk);
					`CHK({sco, szo, csco, cszo}, {v, 2'b00}) // slave
					wr(ADDR_CMD, 32'h0000_0008);
					hw <= 1'b0;
				end
		$display("test start gating done");
		wr(ADDR_IRQ_STAT, 32'h0000_000F);
		wr(ADDR_IRQ_MASK, 32'h0000_0002);
		wr(ADDR_CTRL, 32'h0000_0002);
		wr(ADDR_CMD, 32'h0000_0004);
		wr(ADDR_CMD, 32'h0000_0001);
		@(posedge clk);
		`CHK({chan, sess}, {pat, 1'b1}) // running
		estop <= 1'b1;
		repeat (2) @(posedge clk);
		`CHK({chan, fp, fs, ff, fz, fa, sess}, {32'h0, 6'b111100})
		repeat (6) @(posedge clk);
		`CHK({fp, fs, ff, fz, fa, irq}, 6'b100011) // abort phase two
		e = st(2'd2, 2'd3, 1'b1, 1'b1, 1'b1, 1'b0);
		rd(ADDR_STATUS, e); // aborted flag
		rd(ADDR_IRQ_STAT, 32'h0000_0003);
		wr(ADDR_CMD, 32'h0000_0005);
		`CHK(sess, 1'b0) // no reconnect
		rd(ADDR_STATUS, e); // still held
		wr(ADDR_CMD, 32'h0000_0002);
		wr(ADDR_CMD, 32'h0000_0001);
		rd(ADDR_STATUS, st(2'd2, 2'd0, 1'b0, 1'b1, 1'b1, 1'b0));
		`CHK(fa, 1'b0) // cleared
		wr(ADDR_IRQ_MASK, 32'h0000_0000);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0)
		wr(ADDR_IRQ_STAT, 32'h0000_0002);
		rd(ADDR_IRQ_STAT, 32'h0000_0001);
		estop <= 1'b0;
		wr(ADDR_CMD, 32'h0000_0004);
		`CHK(sess, 1'b1) // reconnect after release
		$display("test abort done");
		wr(ADDR_CTRL, 32'h0000_0010);
		v = {lsc, lsz};
		@(posedge clk);
		`CHK({sco, szo, csco, cszo}, {v, v}) // master
		for (int k = 0; k < 2; k++)
		begin
			dly <= k ? 4'h9 : 4'h1;
			w = $random(seed);
			wr(ADDR_IRQ_STAT, 32'h0000_000F);
			wr(ADDR_CASC_TX, w);
			`CHK(cdo, w) // word sent
			repeat (12) @(posedge clk);
			rd(ADDR_CASC_RX, ~w); // reply taken
			rd(ADDR_IRQ_STAT, 32'h0000_0008);
		end
		$display("test cascade done");
		print_verdict;
	end
endmodule
